// File: verilog/bpc_port.sv
// Eight-bit bidirectional port with weak pull-ups and change interrupt on the upper pins.
//
// Notes on behaviour
// - Direction one is input; zero drives latch.
// - Clearing pullup_disable_n enables pull-ups on input pins.
// - Output pins never have pull-up on.
// - Reset disables every pull-up.
// - Only upper four input pins sensed.
// - Compare against level captured at data read or write.
// - OR of mismatches sets change flag.
// - Change interrupt wakes device from sleep.
// - Data register access refreshes the reference.
// - Mismatch keeps setting flag; set wins.
// - Change during data access sets no flag.
// - Flag sets regardless of enable bits.
`default_nettype none
module bpc_port
    import bpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [ADDR_WIDTH-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic [PORT_WIDTH-1:0] pinIn,
    output logic [PORT_WIDTH-1:0] pinOut,
    output logic [PORT_WIDTH-1:0] pinOe,
    output logic [PORT_WIDTH-1:0] pullupEn,
    input wire logic sleepReq,
    output logic asleep,
    output logic wakeup,
    output logic coreIrq,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] direction;
        logic [7:0] option;
        logic [7:0] intControl;
        logic [3:0] reference;
        logic [1:0] irqStatus;
        logic [1:0] irqMask;
        bpc_power_t power;
        logic [7:0] rdata;
        logic [7:0] pinOut;
        logic [7:0] pinOe;
        logic [7:0] pullupEn;
        logic asleep;
        logic wakeup;
        logic coreIrq;
        logic irq;
    } bpc_state_t;

    bpc_state_t st_q;
    bpc_state_t st_d;
    logic [PORT_WIDTH-1:0] pinSync;
    logic [3:0] senseMask;
    logic [3:0] mismatch;
    logic changeEvent;
    logic dataAccess;

    ////////////////////////////////////////////////////////////////////////////////

    bpc_sync2 u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .asyncIn(pinIn),
        .syncOut(pinSync)
    );

    assign senseMask = st_q.direction[SENSE_HI:SENSE_LO];

    // The per-pin comparators; outputs are masked out of the compare.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cmp
            assign mismatch[gi] = senseMask[gi] &
                (pinSync[SENSE_LO+gi] ^ st_q.reference[gi]);
        end
    endgenerate

    assign changeEvent = |mismatch;
    assign dataAccess = (regRead | regWrite) && (regAddr == ADDR_PIN_DATA);

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_d = st_q;
        st_d.rdata = 8'h00;

        if (regWrite) begin
            if (regAddr == ADDR_PIN_DATA) begin
                st_d.latch = regWdata;
            end else if (regAddr == ADDR_DIRECTION) begin
                st_d.direction = regWdata;
            end else if (regAddr == ADDR_OPTION) begin
                st_d.option = regWdata;
            end else if (regAddr == ADDR_INT_CONTROL) begin
                st_d.intControl = regWdata;
            end else if (regAddr == ADDR_IRQ_STATUS) begin
                st_d.irqStatus = st_q.irqStatus & ~regWdata[1:0];
            end else if (regAddr == ADDR_IRQ_MASK) begin
                st_d.irqMask = regWdata[1:0];
            end
        end

        if (regRead) begin
            if (regAddr == ADDR_PIN_DATA) begin
                // Input pins show the pin level, output pins the latch.
                st_d.rdata = (pinSync & st_q.direction) | (st_q.latch & ~st_q.direction);
            end else if (regAddr == ADDR_DIRECTION) begin
                st_d.rdata = st_q.direction;
            end else if (regAddr == ADDR_OPTION) begin
                st_d.rdata = st_q.option;
            end else if (regAddr == ADDR_INT_CONTROL) begin
                st_d.rdata = st_q.intControl;
            end else if (regAddr == ADDR_IRQ_STATUS) begin
                st_d.rdata = {6'h00, st_q.irqStatus};
            end else if (regAddr == ADDR_IRQ_MASK) begin
                st_d.rdata = {6'h00, st_q.irqMask};
            end
        end

        if (dataAccess) begin
            st_d.reference = pinSync[SENSE_HI:SENSE_LO];
        end

        if (changeEvent && !dataAccess) begin
            st_d.intControl[CHANGE_FLAG_BIT] = 1'b1;
            st_d.irqStatus[0] = 1'b1;
        end
        if (st_q.power == BPC_ASLEEP && st_q.wakeup) begin
            st_d.irqStatus[1] = 1'b1;
        end

        st_d.pinOut = st_q.latch;
        st_d.pinOe = ~st_q.direction;
        st_d.pullupEn = st_q.option[PULLUP_DIS_BIT] ? 8'h00 : st_q.direction;

        st_d.wakeup = st_q.intControl[CHANGE_FLAG_BIT] & st_q.intControl[CHANGE_ENABLE_BIT];
        case (st_q.power)
            BPC_AWAKE: begin
                if (sleepReq && !st_q.wakeup) begin
                    st_d.power = BPC_ASLEEP;
                end
            end
            BPC_ASLEEP: begin
                if (st_q.wakeup) begin
                    st_d.power = BPC_AWAKE;
                end
            end
            default: begin
                st_d.power = BPC_AWAKE;
            end
        endcase
        st_d.asleep = (st_d.power == BPC_ASLEEP);
        st_d.coreIrq = st_q.intControl[CHANGE_FLAG_BIT];
        st_d.irq = |(st_q.irqStatus & st_q.irqMask);

        if (!resetn) begin
            st_d = '0;
            st_d.latch = LATCH_RESET;
            st_d.direction = DIRECTION_RESET;
            st_d.option = OPTION_RESET;
            st_d.intControl = INT_CONTROL_RESET;
            st_d.irqMask = MASK_RESET;
            st_d.power = BPC_AWAKE;
            st_d.pinOe = 8'h00;
            st_d.pullupEn = 8'h00;
        end
    end

    always_ff @(posedge core_clk) begin
        st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign regRdata = st_q.rdata;
    assign pinOut = st_q.pinOut;
    assign pinOe = st_q.pinOe;
    assign pullupEn = st_q.pullupEn;
    assign asleep = st_q.asleep;
    assign wakeup = st_q.wakeup;
    assign coreIrq = st_q.coreIrq;
    assign irq = st_q.irq;
endmodule : bpc_port
`default_nettype wire

// File: pkg/bpc_pkg.sv
// Package of register offsets, field positions and reset values for the change-interrupt port.
`default_nettype none
package bpc_pkg;
    localparam int PORT_WIDTH = 8;
    localparam int ADDR_WIDTH = 3;
    localparam logic [2:0] ADDR_PIN_DATA = 3'h0;
    localparam logic [2:0] ADDR_DIRECTION = 3'h1;
    localparam logic [2:0] ADDR_OPTION = 3'h2;
    localparam logic [2:0] ADDR_INT_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
    localparam int PULLUP_DIS_BIT = 7;
    localparam int CHANGE_FLAG_BIT = 0;
    localparam int CHANGE_ENABLE_BIT = 3;
    localparam int SENSE_LO = 4;
    localparam int SENSE_HI = 7;
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'h80;
    localparam logic [7:0] INT_CONTROL_RESET = 8'h00;
    localparam logic [1:0] MASK_RESET = 2'h0;
    typedef enum logic [1:0] {
        BPC_AWAKE = 2'b00,
        BPC_ASLEEP = 2'b01
    } bpc_power_t;
endpackage : bpc_pkg
`default_nettype wire

// File: verilog/bpc_sync2.sv
// Two-stage synchroniser for the eight port pin inputs.
`default_nettype none
module bpc_sync2
    import bpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [PORT_WIDTH-1:0] asyncIn,
    output logic [PORT_WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [PORT_WIDTH-1:0] first;
        logic [PORT_WIDTH-1:0] second;
    } bpc_sync_t;

    bpc_sync_t s_q;
    bpc_sync_t s_d;

    always_comb begin
        s_d.first = asyncIn;
        s_d.second = s_q.first;
        if (!resetn) begin
            s_d = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        s_q <= s_d;
    end

    assign syncOut = s_q.second;
endmodule : bpc_sync2
`default_nettype wire

// File: tb/bpc_keypad.sv
// Pin model: port driver, key switches, weak pull-ups or a floating line.
`default_nettype none
module bpc_keypad (
    input wire logic core_clk,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] pullupEn,
    input wire logic [7:0] keyVal,
    input wire logic [7:0] keyEn,
    output logic [7:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] noise = 8'h00;
    // A floating line toggles every cycle so that it never reads as a stable level.
    always @(posedge core_clk) noise <= ~noise;
    assign pinIn = (pinOe & pinOut) | (~pinOe & keyEn & keyVal)
        | (~pinOe & ~keyEn & (pullupEn | noise));
endmodule : bpc_keypad
`default_nettype wire

// File: tb/bpc_port_sva.sv
// Checker on the ports of the change-interrupt port.
`default_nettype none
module bpc_port_sva
    import bpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] pinIn,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] pullupEn,
    input wire logic asleep,
    input wire logic wakeup,
    input wire logic coreIrq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    wire logic quiet = !regRead && !regWrite;
    wire logic wrDir = regWrite && regAddr == ADDR_DIRECTION;
    wire logic wrLat = regWrite && regAddr == ADDR_PIN_DATA;
    wire logic wrOpt = regWrite && regAddr == ADDR_OPTION;
    ////////////////////////////////////////////////////////////////////////////////
    a_dir_sets_oe: assert property (wrDir |-> ##2 pinOe == ~$past(regWdata, 2))
        else $error("pin enable wrong");
    a_latch_drives: assert property (wrLat |-> ##2 pinOut == $past(regWdata, 2))
        else $error("pin drive wrong");
    a_pullup_on: assert property (wrOpt && !regWdata[7] ##1 !wrDir |-> ##1 pullupEn == ~pinOe)
        else $error("pull-ups not on");
    a_pullup_off: assert property (wrOpt && regWdata[7] |-> ##2 pullupEn == 8'h00)
        else $error("pull-ups not off");
    a_output_no_pullup: assert property ((pullupEn & pinOe) == 8'h00)
        else $error("pull-up on output");
    a_reset_no_pullup: assert property ($rose(resetn) |-> pullupEn == 8'h00)
        else $error("pull-up after reset");
    a_change_irq: assert property ((!coreIrq && quiet) [*4] ##1
        ($changed(pinIn[7:4]) && quiet && pinOe[7:4] == 4'h0) ##1 quiet [*3] |-> ##[0:1] coreIrq)
        else $error("change flag missed");
    a_wake_exits: assert property (asleep && wakeup |-> ##[1:2] !asleep)
        else $error("no wake");
    c_change: cover property ($rose(coreIrq));
    c_wake: cover property ($fell(asleep));
    c_pullup: cover property ($rose(|pullupEn));
endmodule : bpc_port_sva
bind bpc_port bpc_port_sva chk_u (.*);
`default_nettype wire

// File: tb/tb_bidir_port_change_interrupt.sv
// Self-checking bench for the change-interrupt port.
`default_nettype none
`define BPC_CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_bidir_port_change_interrupt
    import bpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic sleepReq = 1'b0;
    logic [7:0] keyVal = 8'h00;
    logic [7:0] keyEn = 8'hFF;
    logic [7:0] regRdata, pinIn, pinOut, pinOe, pullupEn, v, expV;
    logic asleep, wakeup, coreIrq, irq;
    logic rdPend = 1'b0;
    logic [7:0] expQ[$];
    int error_cnt = 0;
    int checks = 0;
    int seed = 39;
    always #2.5 core_clk = ~core_clk;
    bpc_port dut_u (.*);
    bpc_keypad key_u (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        regRead <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        regAddr <= a;
        regRead <= 1'b1;
        regWrite <= 1'b0;
        expQ.push_back(e);
        @(posedge core_clk);
    endtask : rd
    task automatic idle(input int n);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask : idle
    task automatic end_sim();
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    always @(posedge core_clk) begin
        if (rdPend) begin
            expV = expQ.pop_front();
            `BPC_CHK("regRdata", expV, regRdata)
        end
        rdPend <= regRead;
    end
    initial begin
        #2000;
        error_cnt++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        rd(ADDR_DIRECTION, DIRECTION_RESET);
        rd(ADDR_OPTION, OPTION_RESET);
        wr(3'h7, 8'hFF);
        rd(3'h7, 8'h00);
        rd(ADDR_IRQ_MASK, 8'h00);
        v = 8'($random(seed));
        keyVal <= 8'($random(seed)) & 8'h0F;
        wr(ADDR_DIRECTION, 8'h0F);
        wr(ADDR_PIN_DATA, v);
        idle(4);
        rd(ADDR_PIN_DATA, {v[7:4], keyVal[3:0]});
        wr(ADDR_DIRECTION, 8'hFF);
        idle(4);
        wr(ADDR_PIN_DATA, 8'h00);
        wr(ADDR_INT_CONTROL, 8'h00);
        idle(4);
        rd(ADDR_INT_CONTROL, 8'h00);
        keyVal <= keyVal ^ 8'h04;
        idle(5);
        rd(ADDR_INT_CONTROL, 8'h00);
        idle(4);
        keyVal <= keyVal ^ 8'h10;
        idle(5);
        rd(ADDR_INT_CONTROL, 8'h01);
        wr(ADDR_INT_CONTROL, 8'h00);
        idle(2);
        rd(ADDR_INT_CONTROL, 8'h01);
        rd(ADDR_PIN_DATA, keyVal);
        wr(ADDR_INT_CONTROL, 8'h00);
        idle(2);
        rd(ADDR_INT_CONTROL, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h01);
        idle(2);
        #1 `BPC_CHK("irq", 1'b1, irq)
        wr(ADDR_IRQ_STATUS, 8'h01);
        idle(2);
        #1 `BPC_CHK("irq", 1'b0, irq)
        wr(ADDR_INT_CONTROL, 8'h08);
        sleepReq <= 1'b1;
        idle(3);
        #1 `BPC_CHK("asleep", 1'b1, asleep)
        keyVal <= keyVal ^ 8'h80;
        idle(6);
        #1 `BPC_CHK("asleep", 1'b0, asleep)
        rd(ADDR_IRQ_STATUS, 8'h03);
        sleepReq <= 1'b0;
        wr(ADDR_OPTION, 8'h00);
        keyEn <= 8'h00;
        idle(4);
        rd(ADDR_PIN_DATA, 8'hFF);
        idle(1);
        #1 `BPC_CHK("pullupEn", 8'hFF, pullupEn)
        wr(ADDR_DIRECTION, 8'h0F);
        idle(2);
        #1 `BPC_CHK("pullupEn", 8'h0F, pullupEn)
        resetn <= 1'b0;
        idle(2);
        resetn <= 1'b1;
        #1 `BPC_CHK("pullupEn", 8'h00, pullupEn)
        idle(2);
        end_sim();
    end
endmodule : tb_bidir_port_change_interrupt
`default_nettype wire
